// file: logic/spwp_consts.svh
/*
  Offsets, field positions, key and reset values of the write-protection status bank.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef SPWP_CONSTS_SVH
`define SPWP_CONSTS_SVH

// Register offsets on the peripheral bus
`define SPWP_OFS_PROT_CTRL   8'hE4
`define SPWP_OFS_VIOL_STAT   8'hE8
`define SPWP_OFS_IRQ_STAT    8'hEC
`define SPWP_OFS_IRQ_MASK    8'hF0
`define SPWP_OFS_FEATURE     8'hF8
`define SPWP_OFS_VERSION     8'hFC

// Offsets of the guarded configuration registers
`define SPWP_OFS_MODE_CFG    8'h04
`define SPWP_OFS_SEL_CFG0    8'h30
`define SPWP_SEL_CFG_STRIDE  8'h04

// Protection control fields
`define SPWP_KEY_VALUE       24'h535049
`define SPWP_KEY_LSB         8
`define SPWP_KEY_MSB         31
`define SPWP_PEN_BIT         0

// Violation status fields and reset values
`define SPWP_SRC_LSB         8
`define SPWP_SRC_MSB         15
`define SPWP_KIND_W          3
`define SPWP_VIOL_RESET      32'h00000000
`define SPWP_FEATURE_RESET   32'h001F0154

`endif

// file: logic/spwp_pkg.sv
/*
  Types shared by the write-protection status bank.
  Assumes spwp_consts.svh is on the include path.
*/
package spwp_pkg;
  `include "spwp_consts.svh"

  // One bit per violation kind; packed value is the kind code
  typedef struct packed {
    logic activeWr;
    logic swReset;
    logic blocked;
  } spwp_viol_t;

  // Request part of an APB transfer
  typedef struct packed {
    logic [7:0]  addr;
    logic        write;
    logic [31:0] wdata;
  } spwp_apb_req_t;
endpackage : spwp_pkg

// file: logic/spwp_src_encode.sv
/*
  Finds which guarded configuration register a write touches and whether a select is active.
  Assumes one-cycle write pulses on the same clock as the bank.
*/
`timescale 1ns/100ps
`include "spwp_consts.svh"
module spwp_src_encode
  import spwp_pkg::*;
#(
  parameter int unsigned SELS = 4
)
(
  // Write pulses
  input  wire logic            modeWrite,
  input  wire logic [SELS-1:0] selCfgWrite,
  // Select state
  input  wire logic [SELS-1:0] selActive,
  // Result
  output logic                 anyHit,
  output logic                 activeHit,
  output logic [7:0]           srcOfs
);
  logic [7:0]      ofsTab [SELS];
  logic [SELS-1:0] actHit;

  // Offset and active-write term per select
  for (genvar i = 0; i < SELS; i++)
  begin : g_sel
    assign ofsTab[i] = 8'(`SPWP_OFS_SEL_CFG0 + `SPWP_SEL_CFG_STRIDE * i);
    assign actHit[i] = selCfgWrite[i] & selActive[i];
  end

  // Mode write first, then the lowest select
  always_comb
  begin
    anyHit    = modeWrite | (|selCfgWrite);
    activeHit = (modeWrite & (|selActive)) | (|actHit);
    srcOfs    = 8'h00;
    for (int i = SELS - 1; i >= 0; i--)
    begin
      if (selCfgWrite[i])
        srcOfs = ofsTab[i];
    end
    if (modeWrite)
      srcOfs = `SPWP_OFS_MODE_CFG;
  end
endmodule : spwp_src_encode

// file: logic/spwp_irq_bank.sv
/*
  Sticky event flags with a mask and one level interrupt.
  Assumes the caller clears only flags it has already reported.
*/
`timescale 1ns/100ps
module spwp_irq_bank
  import spwp_pkg::*;
#(
  parameter int unsigned W = 3
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Events and clearing
  input  wire logic [W-1:0] setEv,
  input  wire logic [W-1:0] clrEv,
  // Mask write
  input  wire logic         maskWr,
  input  wire logic [W-1:0] maskData,
  // State
  output logic      [W-1:0] status_q,
  output logic      [W-1:0] mask_q,
  output logic              irq_q
);
  // Sticky flags, set beats clear
  for (genvar b = 0; b < W; b++)
  begin : g_flag
    always_ff @(posedge clk)
    begin
      if (sys_rst)
        status_q[b] <= 1'b0;
      else
        status_q[b] <= setEv[b] | (status_q[b] & ~clrEv[b]);
    end
  end

  // Mask register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mask_q <= '0;
    else if (maskWr)
      mask_q <= maskData;
  end

  // Interrupt level
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq_q <= 1'b0;
    else
      irq_q <= |(status_q & mask_q);
  end
endmodule : spwp_irq_bank

// file: logic/spwp_wp_status.sv
/*
  Write-protection control, violation status, interrupt, feature and version registers
  of a serial peripheral controller, as an APB slave.
  Assumes the rest of the controller gives one-cycle write and reset pulses and select
  levels on clk, and blocks guarded writes while protectEnable is high.
*/
// How it works
// R1 - The source field holds the bus offset of the mode or select config register in the latest blocked or active-select violation.
// R2 - Kind bit value 1 flags a guarded write rejected by protection since the last status read.
// R3 - Kind value 2 flags a soft reset under protection, cleared by status read or a config write.
// R4 - Kind value 4 flags a mode write with any select active or a select config write with its select active.
// R5 - Kinds accumulate, so combined cases read as 3, 5, 6 or 7.
// R6 - The feature register at 0xF8 reports select count and polarity, phase and length options.
// R7 - The feature register flags guard, receive FIFO, select release and decoder, reading 0x001F0154.
// R8 - The version register at 0xFC returns a 12-bit version and a variant with no effect.
// R9 - Software writes the enable bit with key 0x535049 in the top 24 bits; other keys are ignored.
// R10 - The violation status register is read-only, resets to zero, source in 15:8 and kind low.
// R11 - Reading the violation status clears the kind and source fields reported.
`timescale 1ns/100ps
`include "spwp_consts.svh"
module spwp_wp_status
  import spwp_pkg::*;
#(
  parameter int unsigned SELS        = 4,
  parameter logic        POL_CONF    = 1'b1,
  parameter logic        POL_POS     = 1'b0,
  parameter logic        PHA_CONF    = 1'b1,
  parameter logic        PHA_ZERO    = 1'b0,
  parameter logic        LEN_CONF    = 1'b1,
  parameter logic [4:0]  IMPL_FLAGS  = 5'h1F,
  parameter logic [11:0] MOD_VERSION = 12'h100, // Arbitrary value
  parameter logic [3:0]  MOD_VARIANT = 4'h0     // Arbitrary value
)
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            sys_rst,
  // APB slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // Controller events
  input  wire logic            modeWrite,
  input  wire logic [SELS-1:0] selCfgWrite,
  input  wire logic            irqEnWrite,
  input  wire logic            irqDisWrite,
  input  wire logic            softReset,
  input  wire logic [SELS-1:0] selActive,
  // Controller control and interrupt
  output logic                 protectEnable,
  output logic                 irq
);
  localparam int unsigned KW = `SPWP_KIND_W;

  // Refuse select counts the feature field cannot hold
  if (SELS < 1 || SELS > 15)
  begin : g_chk
    $error("spwp_wp_status: SELS must be 1 to 15");
  end

  spwp_apb_req_t req;
  spwp_viol_t    newViol;
  logic          setupCyc;
  logic          accessDone;
  logic          wrDone;
  logic          rdDone;
  logic          mapped;
  logic [31:0]   rdData;
  logic [31:0]   featWord;
  logic [31:0]   versWord;
  logic          srcHit;
  logic          activeHit;
  logic [7:0]    srcOfs;
  logic          cfgTouch;
  logic          keyOk;
  logic [KW-1:0] kindD;
  logic [KW-1:0] istat;
  logic [KW-1:0] imask;
  logic          irqQ;
  logic          violRdClr;
  logic          irqRdClr;
  logic [7:0]    src_q;
  logic [KW-1:0] kind_q;
  logic [KW-1:0] kindSnap_q;
  logic [KW-1:0] irqSnap_q;
  logic          srcFresh_q;
  logic          pen_q;
  logic [31:0]   prdata_q;
  logic          pready_q;
  logic          pslverr_q;

  // Bus request and phase decode
  assign req        = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign setupCyc   = psel & ~penable & ~pready_q;
  assign accessDone = psel & penable & pready_q;
  assign wrDone     = accessDone & req.write;
  assign rdDone     = accessDone & ~req.write;
  assign violRdClr  = rdDone & (req.addr == `SPWP_OFS_VIOL_STAT);
  assign irqRdClr   = rdDone & (req.addr == `SPWP_OFS_IRQ_STAT);

  // Read-only identity words
  assign featWord = {11'h000, IMPL_FLAGS, 7'h00, LEN_CONF, PHA_ZERO, PHA_CONF,
                     POL_POS, POL_CONF, 4'(SELS)}; // [R6] [R7]
  assign versWord = {12'h000, MOD_VARIANT, 4'h0, MOD_VERSION}; // [R8]

  // Which guarded register a write touches
  spwp_src_encode #(
    .SELS (SELS)
  ) u_enc (
    .modeWrite   (modeWrite),
    .selCfgWrite (selCfgWrite),
    .selActive   (selActive),
    .anyHit      (cfgTouch),
    .activeHit   (activeHit),
    .srcOfs      (srcOfs)
  );

  // Violation events this cycle
  always_comb
  begin
    newViol.blocked  = pen_q & cfgTouch; // [R2]
    newViol.swReset  = pen_q & softReset; // [R3]
    newViol.activeWr = activeHit; // [R4]
    srcHit           = newViol.blocked | newViol.activeWr; // [R1]
  end

  // Next kind: clear reported bits, drop reset flag on config writes, sets win
  always_comb
  begin
    kindD = kind_q;
    if (violRdClr)
      kindD = kindD & ~kindSnap_q; // [R11]
    if (cfgTouch | irqEnWrite | irqDisWrite)
      kindD[1] = 1'b0; // [R3]
    kindD = kindD | newViol; // [R5]
  end

  // Violation kind register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      kind_q <= KW'(`SPWP_VIOL_RESET); // [R10]
    else
      kind_q <= kindD;
  end

  // Violation source register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      src_q <= 8'h00; // [R10]
    else if (srcHit)
      src_q <= srcOfs; // [R1]
    else if (violRdClr && !srcFresh_q)
      src_q <= 8'h00; // [R11]
  end

  // Source updated since the status snapshot
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      srcFresh_q <= 1'b0;
    else if (srcHit)
      srcFresh_q <= 1'b1;
    else if (setupCyc && req.addr == `SPWP_OFS_VIOL_STAT)
      srcFresh_q <= 1'b0;
  end

  // Snapshots of what a read reports
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      kindSnap_q <= '0;
      irqSnap_q  <= '0;
    end
    else if (setupCyc)
    begin
      kindSnap_q <= (req.addr == `SPWP_OFS_VIOL_STAT) ? kind_q : '0;
      irqSnap_q  <= (req.addr == `SPWP_OFS_IRQ_STAT) ? istat : '0;
    end
  end

  // Protection enable with key check
  assign keyOk = req.wdata[`SPWP_KEY_MSB:`SPWP_KEY_LSB] == `SPWP_KEY_VALUE; // [R9]
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pen_q <= 1'b0;
    else if (wrDone && req.addr == `SPWP_OFS_PROT_CTRL && keyOk)
      pen_q <= req.wdata[`SPWP_PEN_BIT]; // [R9]
  end

  // Violation events raise interrupt flags
  spwp_irq_bank #(
    .W (KW)
  ) u_irq (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .setEv    (newViol),
    .clrEv    (irqRdClr ? irqSnap_q : '0),
    .maskWr   (wrDone && req.addr == `SPWP_OFS_IRQ_MASK),
    .maskData (req.wdata[KW-1:0]),
    .status_q (istat),
    .mask_q   (imask),
    .irq_q    (irqQ)
  );

  // Read data and decode
  always_comb
  begin
    rdData = 32'h00000000;
    mapped = 1'b1;
    unique case (req.addr)
      `SPWP_OFS_PROT_CTRL: rdData[`SPWP_PEN_BIT] = pen_q;
      `SPWP_OFS_VIOL_STAT:
      begin
        rdData[`SPWP_SRC_MSB:`SPWP_SRC_LSB] = src_q; // [R1]
        rdData[KW-1:0] = kind_q; // [R5]
      end
      `SPWP_OFS_IRQ_STAT:  rdData[KW-1:0] = istat;
      `SPWP_OFS_IRQ_MASK:  rdData[KW-1:0] = imask;
      `SPWP_OFS_FEATURE:   rdData = featWord; // [R6]
      `SPWP_OFS_VERSION:   rdData = versWord; // [R8]
      default:             mapped = 1'b0;
    endcase
  end

  // Bus answer: ready in the first access cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end
    else if (setupCyc)
    begin
      pready_q  <= 1'b1;
      pslverr_q <= ~mapped;
      prdata_q  <= req.write ? 32'h00000000 : rdData;
    end
    else if (accessDone)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Outputs from flip-flops
  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign protectEnable = pen_q;
  assign irq           = irqQ;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Protocol and violation checks
  bus_answer_a: assert property (setupCyc |=> pready_q ##1 !pready_q)
    else $error("Setup not answered in first access cycle");
  blocked_flag_a: assert property (pen_q && modeWrite |=> kind_q[0]) // [R2]
    else $error("Rejected write not flagged");
  reset_flag_a: assert property (pen_q && softReset |=> kind_q[1]) // [R3]
    else $error("Protected soft reset not flagged");
  reset_drop_a: assert property (irqEnWrite && !softReset |=> !kind_q[1]) // [R3]
    else $error("Config write did not drop reset flag");
  active_flag_a: assert property (modeWrite && |selActive |=> kind_q[2]) // [R4]
    else $error("Active-select write not flagged");
  src_mode_a: assert property (modeWrite && pen_q |=> src_q == `SPWP_OFS_MODE_CFG) // [R1]
    else $error("Source not mode offset");
  kind_read_a: assert property (setupCyc && paddr == `SPWP_OFS_VIOL_STAT
    |=> prdata_q[KW-1:0] == $past(kind_q) && prdata_q[31:16] == 16'h0000) // [R10]
    else $error("Status read data wrong");
  combo_code_a: assert property (pen_q && modeWrite && softReset && |selActive
    |=> kind_q == 3'h7) // [R5]
    else $error("Combined kind not 7");
  read_clear_a: assert property (violRdClr && newViol == 3'h0
    |=> (kind_q & $past(kindSnap_q)) == 3'h0) // [R11]
    else $error("Read did not clear reported kind");
  feat_read_a: assert property (setupCyc && paddr == `SPWP_OFS_FEATURE
    |=> prdata_q == featWord) // [R6] [R7]
    else $error("Feature read wrong");
  vers_read_a: assert property (setupCyc && paddr == `SPWP_OFS_VERSION
    |=> prdata_q[31:20] == 12'h000 && prdata_q[11:0] == MOD_VERSION) // [R8]
    else $error("Version read wrong");
  key_guard_a: assert property (wrDone && paddr == `SPWP_OFS_PROT_CTRL && !keyOk
    |=> $stable(pen_q)) // [R9]
    else $error("Keyless write changed enable");
  irq_level_a: assert property (|(istat & imask) |=> irqQ)
    else $error("Interrupt not raised");

  // Main scenarios reached
  blocked_seen_c: cover property (pen_q && modeWrite ##[1:20] violRdClr);
  active_seen_c: cover property (activeHit && |selCfgWrite ##1 kind_q[2]);
  rdclr_seen_c: cover property (violRdClr && kindSnap_q == 3'h7);
  combo_seen_c: cover property (kind_q == 3'h7);
  irq_seen_c: cover property (irqQ ##[1:20] irqRdClr);
endmodule : spwp_wp_status

// file: testbench/spwp_wp_status_tb_top.sv
/*
  Self-checking bench for the write-protection status bank, with a small reference model.
  Assumes spwp_pkg and the design modules are compiled first.
*/
`timescale 1ns/100ps
module spwp_wp_status_tb_top
  import spwp_pkg::*;
;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic        modeWrite, irqEnWrite, irqDisWrite, softReset, protectEnable, irq;
  logic [3:0]  selCfgWrite, selActive;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed, d;
  int          bad_count, checks, mKind, mSrc, mIrq, mProt;

  // Device under test
  spwp_wp_status i_spwp_wp_status (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modeWrite(modeWrite), .selCfgWrite(selCfgWrite), .irqEnWrite(irqEnWrite),
    .irqDisWrite(irqDisWrite), .softReset(softReset), .selActive(selActive),
    .protectEnable(protectEnable), .irq(irq)
  );

  // Free-running 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      bad_count++;
      results();
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  // Read and compare one register
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(a, 1'b0, 32'h0);
    chk(name, rd, exp);
  endtask : rdc

  // Read violation status against the model, then clear the model
  task automatic rdv();
    rdc(8'hE8, {16'h0, mSrc[7:0], 5'h0, mKind[2:0]}, "violation status");
    mKind = 0;
    mSrc = 0;
  endtask : rdv

  // Reference model of one event cycle: v = mode, sel[3:0], reset, irq-en, irq-dis
  task automatic mdl(input logic [7:0] v, input logic [3:0] sa);
    int lo, nw;
    lo = 0;
    nw = 0;
    for (int i = 3; i >= 0; i--)
      if (v[3+i]) lo = i;
    if (v[7:3] != 0 || v[1:0] != 0) mKind &= 5;
    if (mProt != 0 && v[2]) nw |= 2;
    if (mProt != 0 && v[7:3] != 0) nw |= 1;
    if ((v[7] && sa != 0) || (v[6:3] & sa) != 0) nw |= 4;
    if ((nw & 5) != 0) mSrc = v[7] ? 32'h04 : 32'h30 + 4 * lo;
    mKind |= nw;
    mIrq |= nw;
  endtask : mdl

  // Drive one cycle of controller events, then let the flags settle
  task automatic ev(input logic [7:0] v, input logic [3:0] sa);
    @(posedge clk);
    {modeWrite, selCfgWrite, softReset, irqEnWrite, irqDisWrite} <= v;
    selActive <= sa;
    mdl(v, sa);
    @(posedge clk);
    {modeWrite, selCfgWrite, softReset, irqEnWrite, irqDisWrite} <= 8'h00;
    repeat (2) @(posedge clk);
  endtask : ev

  // Protection on or off with the right key
  task automatic prot(input int on);
    apb(8'hE4, 1'b1, {24'h535049, 7'h0, on[0]});
    mProt = on;
    @(posedge clk);
    chk("protect enable", {31'h0, protectEnable}, on);
  endtask : prot

  // Main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, selActive} = '0;
    {modeWrite, selCfgWrite, softReset, irqEnWrite, irqDisWrite} = 8'h00;
    {bad_count, checks, mKind, mSrc, mIrq, mProt} = '0;
    seed = 32'd94387;
    sys_rst = 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rdv();
    rdc(8'hF8, 32'h001F0154, "features");
    rdc(8'hFC, 32'h00000100, "version");
    apb(8'hE8, 1'b1, 32'hFFFFFFFF);
    rdv();
    apb(8'h80, 1'b0, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("reset and identity test done");
    // Wrong keys leave protection off
    repeat (4)
    begin
      d = rnd();
      if (d[31:8] == 24'h535049) d[8] = ~d[8];
      apb(8'hE4, 1'b1, {d[31:8], 8'h01});
    end
    chk("protect after bad key", {31'h0, protectEnable}, 32'h0);
    ev(8'h80, 4'h0);
    rdv();
    prot(1);
    apb(8'hF0, 1'b1, 32'h7);
    ev(8'h80, 4'h0);
    chk("irq raised", {31'h0, irq}, 32'h1);
    rdv();
    rdv();
    rdc(8'hEC, mIrq, "irq status");
    mIrq = 0;
    repeat (3) @(posedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    apb(8'hF0, 1'b1, 32'h0);
    ev(8'h80, 4'h0);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rdv();
    $display("protect and interrupt test done");
    // Combined kinds
    ev(8'h80, 4'h0);
    ev(8'h04, 4'h0);
    rdv();
    ev(8'h20, 4'h4);
    rdv();
    ev(8'h20, 4'h4);
    ev(8'h04, 4'h4);
    rdv();
    ev(8'h04, 4'h0);
    ev(8'h02, 4'h0);
    rdv();
    ev(8'h05, 4'h0);
    rdv();
    prot(0);
    ev(8'h80, 4'h1);
    prot(1);
    ev(8'h04, 4'h0);
    rdv();
    ev(8'h84, 4'h2);
    rdv();
    prot(0);
    $display("combined kind test done");
    // Random writes against random select states
    repeat (12)
    begin
      d = rnd();
      ev(d[7:0] & 8'hF8, d[11:8]);
      rdv();
    end
    $display("random select test done");
    results();
  end
endmodule : spwp_wp_status_tb_top
